// [design/lpt_pkg.sv]
// Purpose: shared constants and types of the low-power timer
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes: flag layout is common to status, clear and interrupt-enable registers
package lpt_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_STATUS = 8'h00; // timer_flag_status_reg, read only
	localparam logic [7:0] OFF_CLEAR = 8'h04; // timer_flag_clear_reg, write one to clear
	localparam logic [7:0] OFF_IER = 8'h08; // interrupt enable (mask)
	localparam logic [7:0] OFF_CTRL = 8'h0c; // timer_control_reg
	localparam logic [7:0] OFF_CMP = 8'h10; // compare value
	localparam logic [7:0] OFF_ARR = 8'h14; // auto-reload value
	localparam logic [7:0] OFF_CNT = 8'h18; // timer_counter_value, read only
	localparam logic [7:0] OFF_CFG = 8'h1c; // periph_clock_select_reg copy
	// field positions
	localparam int FLAG_CMP = 0; // compare_match_event flag
	localparam int FLAG_ARR = 1; // autoreload_match_event flag
	localparam int CTRL_EN = 0; // timer enable
	localparam int NFLAG = 2; // number of flags
	localparam int CW = 16; // counter width
	// reset values
	localparam logic [CW-1:0] RST_ARR = 16'hffff; // auto-reload after reset
	localparam logic [CW-1:0] RST_CMP = 16'h0000; // compare after reset
	// synchronised pin inputs: four clock sources, then two oscillator status levels
	localparam int NSYNC = 6;
	localparam int SYN_OSC1ON = 4; // first_low_speed_osc running
	localparam int SYN_OSC2ON = 5; // second_low_speed_osc running
	// timer_kernel_clock_select encoding
	typedef enum logic [1:0] {
		LPT_SEL_BUS = 2'b00, // bus clock, tick every cycle
		LPT_SEL_LOW = 2'b01, // internal_low_speed_clock
		LPT_SEL_EXT = 2'b10, // external low-speed clock
		LPT_SEL_HS = 2'b11 // high-speed internal clock
	} lpt_clksel_e;
	// APB request group
	typedef struct packed {
		logic psel; // select
		logic penable; // access phase
		logic pwrite; // direction
		logic [7:0] paddr; // byte address
		logic [31:0] pwdata; // write data
	} lpt_apb_s;
endpackage : lpt_pkg

// [design/lpt_timer.sv]
// Purpose: low-power timer with compare/auto-reload events, PWM and interrupt
// Assumes: kernel clock sources arrive as pins and are sampled on clk_sys
// Notes: peripheral reset bit from the reset controller clears the whole timer
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// - events, PWM, flags lag match by one tick
// - no exact 100% duty; compare at or above auto-reload holds PWM low (0%)
// - writing one to clear register clears flag
// - clear colliding with new event never sticks irq
// - low-speed select needs first oscillator running
// - clearing enable never freezes wake-up interrupt
module lpt_timer (
	input wire logic clk_sys, // system clock, 250 MHz
	input wire logic rst_n, // asynchronous reset, active low
	input wire lpt_pkg::lpt_apb_s apbReq, // APB request group
	output logic pready, // APB ready
	output logic [31:0] prdata, // APB read data
	output logic pslverr, // APB error for unmapped address
	input wire logic periphResetPin, // timer_periph_reset_bit level
	input wire logic [lpt_pkg::NSYNC-1:0] srcPins, // clock sources and oscillator status
	output logic compareMatchEvent, // one-cycle compare event pulse
	output logic autoreloadMatchEvent, // one-cycle auto-reload event pulse
	output logic pwmOut, // PWM level
	output logic irq // level interrupt, also the wake-up request
);
	logic [lpt_pkg::NSYNC-1:0] sync1_r; // first synchroniser stage
	logic [lpt_pkg::NSYNC-1:0] sync2_r; // second synchroniser stage
	logic [lpt_pkg::NSYNC-1:0] sync3_r; // edge-detect history
	logic rst1_r; // peripheral reset, first stage
	logic rst2_r; // peripheral reset, second stage
	logic pready_r; // ready for access phase
	logic [31:0] prdata_r; // captured read data
	logic pslverr_r; // captured error
	logic [lpt_pkg::NFLAG-1:0] status_r; // sticky flags
	logic [lpt_pkg::NFLAG-1:0] status_nxt; // next flags
	logic [lpt_pkg::NFLAG-1:0] ier_r; // interrupt enable
	logic en_r; // timer enable
	logic [1:0] sel_r; // timer_kernel_clock_select
	logic [lpt_pkg::CW-1:0] cmp_r; // compare value
	logic [lpt_pkg::CW-1:0] arr_r; // auto-reload value
	logic [lpt_pkg::CW-1:0] cnt_r; // counter
	logic cmpSeen_r; // counter met compare on last tick
	logic arrSeen_r; // counter met auto-reload on last tick
	logic cmpEvt_r; // compare event pulse
	logic arrEvt_r; // auto-reload event pulse
	logic pwm_r; // PWM level
	logic irq_r; // interrupt level

	// synchronise every pin input, one generate lane per bit
	genvar gi;
	generate
		for (gi = 0; gi < lpt_pkg::NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= srcPins[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
				end
			end
		end
	endgenerate

	// peripheral reset bit synchroniser
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst1_r <= 1'b0;
			rst2_r <= 1'b0;
		end else begin
			rst1_r <= periphResetPin;
			rst2_r <= rst1_r;
		end
	end

	wire softRst = rst2_r; // whole-timer reset while held
	wire [3:0] srcEdge = sync2_r[3:0] & ~sync3_r[3:0]; // rising edges of sources
	wire osc1On = sync2_r[lpt_pkg::SYN_OSC1ON]; // first oscillator running
	wire osc2On = sync2_r[lpt_pkg::SYN_OSC2ON]; // second oscillator running
	// low-speed clock comes from the second oscillator when it is active
	wire lowSpdEdge = osc2On ? srcEdge[1] : srcEdge[0];
	// the first oscillator gates the low-speed tick even when the second oscillator supplies it
	wire lowSpdTick = lowSpdEdge & osc1On;
	wire srcTick = (sel_r == lpt_pkg::LPT_SEL_BUS) ? 1'b1 :
		(sel_r == lpt_pkg::LPT_SEL_LOW) ? lowSpdTick :
		(sel_r == lpt_pkg::LPT_SEL_EXT) ? srcEdge[2] : srcEdge[3];
	wire tick = en_r & srcTick & ~softRst; // kernel clock tick
	wire cmpHit = (cnt_r == cmp_r); // compare match on current count
	wire arrHit = (cnt_r == arr_r); // auto-reload match on current count
	wire cmpFire = tick & cmpSeen_r; // compare event one tick late
	wire arrFire = tick & arrSeen_r; // auto-reload event one tick late

	// APB decode
	wire setup = apbReq.psel & ~apbReq.penable; // setup phase
	wire wrAcc = apbReq.psel & apbReq.penable & pready_r & apbReq.pwrite; // write commit
	wire [7:0] addr = apbReq.paddr; // byte address
	wire hitStatus = (addr == lpt_pkg::OFF_STATUS);
	wire hitClear = (addr == lpt_pkg::OFF_CLEAR);
	wire hitIer = (addr == lpt_pkg::OFF_IER);
	wire hitCtrl = (addr == lpt_pkg::OFF_CTRL);
	wire hitCmp = (addr == lpt_pkg::OFF_CMP);
	wire hitArr = (addr == lpt_pkg::OFF_ARR);
	wire hitCnt = (addr == lpt_pkg::OFF_CNT);
	wire hitCfg = (addr == lpt_pkg::OFF_CFG);
	wire mapped = hitStatus | hitClear | hitIer | hitCtrl | hitCmp | hitArr | hitCnt | hitCfg;
	wire [31:0] rdMux = hitStatus ? {30'h0, status_r} :
		hitIer ? {30'h0, ier_r} :
		hitCtrl ? {31'h0, en_r} :
		hitCmp ? {16'h0, cmp_r} :
		hitArr ? {16'h0, arr_r} :
		hitCnt ? {16'h0, cnt_r} :
		hitCfg ? {30'h0, sel_r} : 32'h0;
	// clear register reads as zero; clears only on a committed write
	wire [lpt_pkg::NFLAG-1:0] clrMask = (wrAcc & hitClear) ?
		apbReq.pwdata[lpt_pkg::NFLAG-1:0] : 2'h0;
	wire [lpt_pkg::NFLAG-1:0] setMask = {arrFire, cmpFire}; // flag set requests

	// set wins over clear so a colliding clear never loses an event or sticks irq
	assign status_nxt = softRst ? 2'h0 : (setMask | (status_r & ~clrMask));

	// APB slave: answers one cycle after setup, no wait states
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setup;
			prdata_r <= setup ? rdMux : 32'h0;
			pslverr_r <= setup & ~mapped;
		end
	end

	// software-written registers, all returned to their reset values by the peripheral reset bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ier_r <= 2'h0;
			en_r <= 1'b0;
			sel_r <= 2'h0;
			cmp_r <= lpt_pkg::RST_CMP;
			arr_r <= lpt_pkg::RST_ARR;
		end else if (softRst) begin
			ier_r <= 2'h0;
			en_r <= 1'b0;
			sel_r <= 2'h0;
			cmp_r <= lpt_pkg::RST_CMP;
			arr_r <= lpt_pkg::RST_ARR;
		end else if (wrAcc) begin
			if (hitIer) ier_r <= apbReq.pwdata[lpt_pkg::NFLAG-1:0];
			if (hitCtrl) en_r <= apbReq.pwdata[lpt_pkg::CTRL_EN];
			if (hitCfg) sel_r <= apbReq.pwdata[1:0];
			if (hitCmp) cmp_r <= apbReq.pwdata[lpt_pkg::CW-1:0];
			if (hitArr) arr_r <= apbReq.pwdata[lpt_pkg::CW-1:0];
		end
	end

	// counter and one-tick-late match pipeline
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 16'h0;
			cmpSeen_r <= 1'b0;
			arrSeen_r <= 1'b0;
		end else if (softRst) begin
			cnt_r <= 16'h0;
			cmpSeen_r <= 1'b0;
			arrSeen_r <= 1'b0;
		end else if (tick) begin
			cnt_r <= arrHit ? 16'h0 : cnt_r + 16'h1; // wrap at auto-reload
			cmpSeen_r <= cmpHit;
			arrSeen_r <= arrHit;
		end
	end

	// events, PWM and irq; irq follows the flags so disabling can never freeze it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmpEvt_r <= 1'b0;
			arrEvt_r <= 1'b0;
			pwm_r <= 1'b0;
			status_r <= 2'h0;
			irq_r <= 1'b0;
		end else begin
			cmpEvt_r <= cmpFire;
			arrEvt_r <= arrFire;
			// the late update makes a full-period high level impossible; compare at or above auto-reload keeps it low
			if (softRst) pwm_r <= 1'b0;
			else if (arrFire) pwm_r <= 1'b0;
			else if (cmpFire) pwm_r <= 1'b1;
			status_r <= status_nxt;
			irq_r <= |(status_nxt & ier_r);
		end
	end

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign compareMatchEvent = cmpEvt_r;
	assign autoreloadMatchEvent = arrEvt_r;
	assign pwmOut = pwm_r;
	assign irq = irq_r;

	// checks
	property p_cmp_late;
		@(posedge clk_sys) disable iff (!rst_n)
		(tick && cmpHit) ##1 tick |=> cmpEvt_r;
	endproperty
	a_cmp_late: assert property (p_cmp_late) else $error("compare event not one tick late");
	property p_arr_late;
		@(posedge clk_sys) disable iff (!rst_n)
		arrEvt_r |-> $past(arrSeen_r) && !$past(softRst);
	endproperty
	a_arr_late: assert property (p_arr_late) else $error("reload event without prior match");
	property p_pwm_low;
		@(posedge clk_sys) disable iff (!rst_n)
		arrEvt_r |-> !pwm_r;
	endproperty
	a_pwm_low: assert property (p_pwm_low) else $error("pwm not low after reload");
	property p_pwm_high;
		@(posedge clk_sys) disable iff (!rst_n)
		(cmpEvt_r && !arrEvt_r && !$past(softRst)) |-> pwm_r;
	endproperty
	a_pwm_high: assert property (p_pwm_high) else $error("pwm not high after compare");
	property p_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		(clrMask[0] && !cmpFire) |=> !status_r[0];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared by write");
	property p_set_wins;
		@(posedge clk_sys) disable iff (!rst_n)
		(|setMask) |=> ((status_r & $past(setMask)) == $past(setMask));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost against clear");
	property p_irq;
		@(posedge clk_sys) disable iff (!rst_n)
		irq_r == |(status_r & $past(ier_r));
	endproperty
	a_irq: assert property (p_irq) else $error("irq does not follow enabled flags");
	property p_osc1_gate;
		@(posedge clk_sys) disable iff (!rst_n)
		(sel_r == lpt_pkg::LPT_SEL_LOW && !osc1On) |-> !tick;
	endproperty
	a_osc1_gate: assert property (p_osc1_gate) else $error("timer ran without first osc");
	property p_disabled;
		@(posedge clk_sys) disable iff (!rst_n)
		(!en_r && !softRst) |=> (cnt_r == $past(cnt_r)) && !cmpEvt_r;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled timer still counting");
	property p_soft_rst;
		@(posedge clk_sys) disable iff (!rst_n)
		softRst |=> (cnt_r == 16'h0) && (status_r == 2'h0) && !irq_r;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("peripheral reset left state");
	property p_apb_ready;
		@(posedge clk_sys) disable iff (!rst_n)
		setup |=> pready_r ##1 !pready_r;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb ready not one cycle");
endmodule : lpt_timer

// [dv/low_power_timer_events_tb.sv]
// Purpose: self-checking bench for the low-power timer
// Assumes: APB access phase answers within a few cycles; bus-clock ticks for event timing
// Notes: kernel source pins are slow square waves made from a free counter
`timescale 1ns/1ps
module low_power_timer_events_tb;
	logic clk_sys = 1'b0; // system clock
	logic rst_n = 1'b0; // async reset, active low
	lpt_pkg::lpt_apb_s apbReq = '0; // bus request group
	logic pready; // bus ready
	logic [31:0] prdata; // read data
	logic pslverr; // bus error
	logic periphResetPin = 1'b0; // peripheral reset level
	logic [3:0] srcClk = 4'h0; // kernel clock pins
	logic [1:0] oscOn = 2'h0; // oscillator running levels
	logic compareMatchEvent; // compare pulse
	logic autoreloadMatchEvent; // reload pulse
	logic pwmOut; // pwm level
	logic irq; // interrupt level
	int n_fail = 0; // mismatches
	int checks = 0; // comparisons made
	logic [31:0] rd; // last read word
	logic err; // last error bit
	logic [31:0] rd0; // earlier counter read
	int n; // cycles between events
	// 250 MHz clock
	always #2 clk_sys = ~clk_sys;
	// free counter: each bit is a slower square wave, all far below clk_sys/2 after bit 0
	always @(posedge clk_sys) begin
		srcClk <= srcClk + 4'h1;
	end
	lpt_timer lpt_timer_i (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.apbReq(apbReq),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.periphResetPin(periphResetPin),
		.srcPins({oscOn, srcClk}),
		.compareMatchEvent(compareMatchEvent),
		.autoreloadMatchEvent(autoreloadMatchEvent),
		.pwmOut(pwmOut),
		.irq(irq)
	);
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one APB transfer; request held until pready is seen high
	task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int k;
		@(posedge clk_sys);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
		@(posedge clk_sys);
		apbReq.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) chk(32'h0, 32'h1);
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask : apb
	task rdchk(input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	// bounded wait for one event pulse, n counts edges waited
	task wait_ev(input logic rel);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while ((rel ? autoreloadMatchEvent : compareMatchEvent) !== 1'b1 && n < 64);
	endtask : wait_ev
	task t_reset;
		rdchk(lpt_pkg::OFF_ARR, 32'h0000ffff);
		rdchk(lpt_pkg::OFF_STATUS, 32'h0);
		rdchk(lpt_pkg::OFF_CLEAR, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk({31'h0, irq}, 32'h0);
	endtask : t_reset
	task t_events;
		apb(1'b1, lpt_pkg::OFF_CMP, 32'h2);
		apb(1'b1, lpt_pkg::OFF_ARR, 32'h4);
		apb(1'b1, lpt_pkg::OFF_CTRL, 32'h1);
		wait_ev(1'b0);
		chk({31'h0, pwmOut}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wait_ev(1'b1);
		chk(n, 32'h2);
		chk({31'h0, pwmOut}, 32'h0);
		wait_ev(1'b0);
		chk(n, 32'h3);
		apb(1'b1, lpt_pkg::OFF_IER, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, 32'h1);
		// handler entered: masked flag cleared first, while events keep landing
		repeat (12) apb(1'b1, lpt_pkg::OFF_CLEAR, 32'h2);
		apb(1'b1, lpt_pkg::OFF_CTRL, 32'h0);
		apb(1'b1, lpt_pkg::OFF_CLEAR, 32'h2);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, lpt_pkg::OFF_CLEAR, 32'h1);
		rdchk(lpt_pkg::OFF_STATUS, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, 32'h0);
	endtask : t_events
	task t_periph;
		apb(1'b1, lpt_pkg::OFF_IER, 32'h3);
		apb(1'b1, lpt_pkg::OFF_ARR, 32'h9);
		periphResetPin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		periphResetPin <= 1'b0;
		repeat (6) @(posedge clk_sys);
		rdchk(lpt_pkg::OFF_IER, 32'h0);
		rdchk(lpt_pkg::OFF_ARR, 32'h0000ffff);
		rdchk(lpt_pkg::OFF_CTRL, 32'h0);
		rdchk(lpt_pkg::OFF_CNT, 32'h0);
		rdchk(lpt_pkg::OFF_STATUS, 32'h0);
		chk({31'h0, pwmOut}, 32'h0);
	endtask : t_periph
	task t_osc;
		apb(1'b1, lpt_pkg::OFF_CFG, 32'h1);
		oscOn <= 2'b10;
		apb(1'b1, lpt_pkg::OFF_CTRL, 32'h1);
		repeat (40) @(posedge clk_sys);
		rdchk(lpt_pkg::OFF_CNT, 32'h0);
		oscOn <= 2'b11;
		repeat (40) @(posedge clk_sys);
		apb(1'b0, lpt_pkg::OFF_CNT, 32'h0);
		chk({31'h0, (rd !== 32'h0) && (^rd !== 1'bx)}, 32'h1);
	endtask : t_osc
	// other kernel sources: the counter must advance on the selected pin
	task t_src(input logic [31:0] sel);
		apb(1'b1, lpt_pkg::OFF_CFG, sel);
		apb(1'b0, lpt_pkg::OFF_CNT, 32'h0);
		rd0 = rd;
		repeat (40) @(posedge clk_sys);
		apb(1'b0, lpt_pkg::OFF_CNT, 32'h0);
		chk({31'h0, rd != rd0}, 32'h1);
	endtask : t_src
	// verdict and end of run
	task conclude;
		if (n_fail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	// main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_events();
		t_periph();
		t_osc();
		t_src(32'h2);
		t_src(32'h3);
		conclude();
	end
	// watchdog: whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end
endmodule : low_power_timer_events_tb
